// [src/mct_pkg.sv]
// Purpose: shared constants, types and the opcode timing table of the core
// Assumes: one system clock; every figure is counted in single clocks
// Notes: timing gives bytes, base clocks and whether a taken jump adds one
package mct_pkg;

  // -----------------------------------------------------------------
  // special function register addresses
  // -----------------------------------------------------------------
  localparam logic [7:0] SFR_ACC = 8'hE0;
  localparam logic [7:0] SFR_B = 8'hF0;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;

  // -----------------------------------------------------------------
  // status flag positions and reset values
  // -----------------------------------------------------------------
  localparam int FLG_CY = 7;
  localparam int FLG_AC = 6;
  localparam int FLG_OV = 2;
  localparam int FLG_P = 0;
  localparam int FLG_RS_HI = 4;
  localparam int FLG_RS_LO = 3;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // -----------------------------------------------------------------
  // opcodes with a behaviour of their own
  // -----------------------------------------------------------------
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_DA = 8'hD4;
  localparam logic [7:0] OP_CLR_A = 8'hE4;
  localparam logic [7:0] OP_CPL_A = 8'hF4;
  localparam logic [7:0] OP_SWAP = 8'hC4;
  localparam logic [7:0] OP_RR = 8'h03;
  localparam logic [7:0] OP_RRC = 8'h13;
  localparam logic [7:0] OP_RL = 8'h23;
  localparam logic [7:0] OP_RLC = 8'h33;
  localparam logic [7:0] OP_CLR_C = 8'hC3;
  localparam logic [7:0] OP_SETB_C = 8'hD3;
  localparam logic [7:0] OP_CPL_C = 8'hB3;
  localparam logic [7:0] OP_INC_DP = 8'hA3;
  localparam logic [7:0] OP_LD_DP = 8'h90;
  localparam logic [7:0] OP_MOV_AI = 8'h74;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_SJMP = 8'h80;

  // -----------------------------------------------------------------
  // high nibble groups
  // -----------------------------------------------------------------
  localparam logic [3:0] HI_INC = 4'h0;
  localparam logic [3:0] HI_DEC = 4'h1;
  localparam logic [3:0] HI_ADD = 4'h2;
  localparam logic [3:0] HI_ADDC = 4'h3;
  localparam logic [3:0] HI_OR = 4'h4;
  localparam logic [3:0] HI_AND = 4'h5;
  localparam logic [3:0] HI_XOR = 4'h6;
  localparam logic [3:0] HI_MOVI = 4'h7;
  localparam logic [3:0] HI_SUBB = 4'h9;
  localparam logic [3:0] HI_MOVA = 4'hE;
  localparam logic [3:0] HI_MOVM = 4'hF;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    ALU_ADD = 4'b0000, ALU_ADDC = 4'b0001, ALU_SUBB = 4'b0010,
    ALU_INC = 4'b0011, ALU_DEC = 4'b0100, ALU_AND = 4'b0101,
    ALU_OR = 4'b0110, ALU_XOR = 4'b0111, ALU_DA = 4'b1000
  } mct_alu_op_t;

  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cyc;
    logic branch;
  } mct_timing_t;

  typedef struct packed {
    logic [7:0] res;
    logic cy;
    logic ac;
    logic ov;
  } mct_alu_res_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic ov;
  } mct_md_res_t;

  function automatic mct_timing_t mct_tm(input logic [1:0] l,
                                         input logic [3:0] c,
                                         input logic b);
    return '{len: l, cyc: c, branch: b};
  endfunction : mct_tm

  // bytes and clocks per opcode
  function automatic mct_timing_t mct_timing(input logic [7:0] op);
    mct_timing_t t;
    logic [3:0] h;
    t = mct_tm(2'h1, 4'h1, 1'h0);
    h = op[7:4];
    case (op[3:0])
      4'h0: begin
        case (h)
          4'h0: t = mct_tm(2'h1, 4'h1, 1'h0);
          4'h1, 4'h2, 4'h3: t = mct_tm(2'h3, 4'h3, 1'h1);
          4'h4, 4'h5, 4'h6, 4'h7, 4'h8: t = mct_tm(2'h2, 4'h2, 1'h1);
          4'h9: t = mct_tm(2'h3, 4'h3, 1'h0);
          4'hE, 4'hF: t = mct_tm(2'h1, 4'h3, 1'h0);
          default: t = mct_tm(2'h2, 4'h2, 1'h0);
        endcase
      end
      4'h1: t = mct_tm(2'h2, 4'h3, 1'h0);
      4'h2: begin
        case (h)
          4'h0, 4'h1: t = mct_tm(2'h3, 4'h4, 1'h0);
          4'h2, 4'h3: t = mct_tm(2'h1, 4'h5, 1'h0);
          4'hE, 4'hF: t = mct_tm(2'h1, 4'h3, 1'h0);
          default: t = mct_tm(2'h2, 4'h2, 1'h0);
        endcase
      end
      4'h3: begin
        case (h)
          4'h4, 4'h5, 4'h6: t = mct_tm(2'h3, 4'h3, 1'h0);
          4'h7, 4'h8, 4'h9, 4'hE, 4'hF: t = mct_tm(2'h1, 4'h3, 1'h0);
          default: t = mct_tm(2'h1, 4'h1, 1'h0);
        endcase
      end
      4'h4: begin
        case (h)
          4'h8: t = mct_tm(2'h1, 4'h8, 1'h0);
          4'hA: t = mct_tm(2'h1, 4'h4, 1'h0);
          4'hB: t = mct_tm(2'h3, 4'h3, 1'h1);
          4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9:
            t = mct_tm(2'h2, 4'h2, 1'h0);
          default: t = mct_tm(2'h1, 4'h1, 1'h0);
        endcase
      end
      4'h5: begin
        case (h)
          4'h7, 4'h8: t = mct_tm(2'h3, 4'h3, 1'h0);
          4'hB, 4'hD: t = mct_tm(2'h3, 4'h3, 1'h1);
          4'hA: t = mct_tm(2'h1, 4'h1, 1'h0);
          default: t = mct_tm(2'h2, 4'h2, 1'h0);
        endcase
      end
      4'h6, 4'h7: begin
        case (h)
          4'h7, 4'h8, 4'hA: t = mct_tm(2'h2, 4'h2, 1'h0);
          4'hB: t = mct_tm(2'h3, 4'h4, 1'h1);
          default: t = mct_tm(2'h1, 4'h2, 1'h0);
        endcase
      end
      default: begin
        case (h)
          4'h7, 4'h8, 4'hA: t = mct_tm(2'h2, 4'h2, 1'h0);
          4'hB: t = mct_tm(2'h3, 4'h3, 1'h1);
          4'hD: t = mct_tm(2'h2, 4'h2, 1'h1);
          default: t = mct_tm(2'h1, 4'h1, 1'h0);
        endcase
      end
    endcase
    return t;
  endfunction : mct_timing

endpackage : mct_pkg

// [src/mct_alu.sv]
// Purpose: byte arithmetic and logic with carry, half carry and overflow
// Assumes: purely combinational, driven by the core's decode
// Notes: carry and half carry not touched by an operation pass through unchanged; overflow reads zero
module mct_alu
  import mct_pkg::*;
(
  // operation and operands
  input wire mct_alu_op_t i_op,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire logic i_cy,
  input wire logic i_ac,
  // result
  output mct_alu_res_t o_res
);

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  // one process covers every operation
  always_comb begin
    logic [8:0] s;
    logic [4:0] n;
    logic cin;
    logic c;
    s = 9'h000;
    n = 5'h00;
    c = 1'h0;
    cin = (i_op == ALU_ADD) ? 1'h0 : i_cy;
    o_res = '{res: i_a, cy: i_cy, ac: i_ac, ov: 1'h0};
    case (i_op)
      ALU_ADD, ALU_ADDC: begin
        s = {1'h0, i_a} + {1'h0, i_b} + {8'h00, cin};
        n = {1'h0, i_a[3:0]} + {1'h0, i_b[3:0]} + {4'h0, cin};
        o_res.res = s[7:0];
        o_res.cy = s[8];
        o_res.ac = n[4];
        o_res.ov = (i_a[7] == i_b[7]) && (s[7] != i_a[7]);
      end
      ALU_SUBB: begin
        s = {1'h0, i_a} - {1'h0, i_b} - {8'h00, i_cy};
        n = {1'h0, i_a[3:0]} - {1'h0, i_b[3:0]} - {4'h0, i_cy};
        o_res.res = s[7:0];
        o_res.cy = s[8];
        o_res.ac = n[4];
        o_res.ov = (i_a[7] != i_b[7]) && (s[7] != i_a[7]);
      end
      ALU_INC: o_res.res = i_a + 8'h01;
      ALU_DEC: o_res.res = i_a - 8'h01;
      ALU_AND: o_res.res = i_a & i_b;
      ALU_OR: o_res.res = i_a | i_b;
      ALU_XOR: o_res.res = i_a ^ i_b;
      ALU_DA: begin
        // bcd correction, carry may only be set, never cleared
        s = {1'h0, i_a};
        if ((i_a[3:0] > 4'h9) || i_ac) begin
          s = s + 9'h006;
        end
        c = i_cy | s[8];
        if ((s[7:4] > 4'h9) || c) begin
          s = {1'h0, s[7:0]} + 9'h060;
        end
        o_res.res = s[7:0];
        o_res.cy = c | s[8];
      end
      default: o_res.res = i_a;
    endcase
  end

endmodule : mct_alu

// [src/mct_muldiv.sv]
// Purpose: stepped multiply and divide of accumulator by b
// Assumes: load in the opcode clock, result read as a look-ahead step
// Notes: multiply settles in the fourth clock, divide in the eighth
module mct_muldiv
  import mct_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // control and operands
  input wire logic i_load,
  input wire logic i_div,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  // result
  output mct_md_res_t o_res
);

  logic [15:0] prod_reg;
  logic [15:0] mcand_reg;
  logic [7:0] mplier_reg;
  logic [7:0] rem_reg;
  logic [7:0] quo_reg;
  logic [7:0] dvs_reg;

  // ---------------------------------------------------------------
  // step sources: fresh operands on load, held state otherwise
  // ---------------------------------------------------------------
  wire logic [15:0] prod_s = i_load ? 16'h0000 : prod_reg;
  wire logic [15:0] mcand_s = i_load ? {8'h00, i_a} : mcand_reg;
  wire logic [7:0] mplier_s = i_load ? i_b : mplier_reg;
  wire logic [7:0] rem_s = i_load ? 8'h00 : rem_reg;
  wire logic [7:0] quo_s = i_load ? i_a : quo_reg;
  wire logic [7:0] dvs_s = i_load ? i_b : dvs_reg;

  // two multiplier bits and one quotient bit per clock
  wire logic [15:0] pp0 = mplier_s[0] ? mcand_s : 16'h0000;
  wire logic [15:0] pp1 = mplier_s[1] ? {mcand_s[14:0], 1'h0} : 16'h0000;
  wire logic [15:0] prod_next = prod_s + pp0 + pp1;
  wire logic [8:0] trial = {rem_s, quo_s[7]};
  wire logic ge = trial >= {1'h0, dvs_s};
  wire logic [8:0] diff = trial - {1'h0, dvs_s};
  wire logic [7:0] rem_next = ge ? diff[7:0] : trial[7:0];
  wire logic [7:0] quo_next = {quo_s[6:0], ge};

  // look-ahead result; divide by zero flags overflow
  assign o_res.lo = i_div ? quo_next : prod_next[7:0];
  assign o_res.hi = i_div ? rem_next : prod_next[15:8];
  assign o_res.ov = i_div ? (dvs_s == 8'h00) : (prod_next[15:8] != 8'h00);

  // step state every clock
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      prod_reg <= 16'h0000;
      mcand_reg <= 16'h0000;
      mplier_reg <= 8'h00;
      rem_reg <= 8'h00;
      quo_reg <= 8'h00;
      dvs_reg <= 8'h00;
    end else begin
      prod_reg <= prod_next;
      mcand_reg <= {mcand_s[13:0], 2'h0};
      mplier_reg <= {2'h0, mplier_s[7:2]};
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      dvs_reg <= dvs_s;
    end
  end

endmodule : mct_muldiv

// [src/mct_core.sv]
// Purpose: non-pipelined 8-bit core, one program byte taken per clock
// Assumes: program memory answers i_code_byte for o_code_addr in-cycle
// Notes: unlisted opcodes keep their clock count but change no state
//
// How it works
// - opcodes, addressing modes and flag effects follow the standard set.
// - time is counted in single system clocks, no machine cycles.
// - most instructions take as many clocks as they have bytes.
// - a conditional jump not taken ends one clock before a taken one.
// - nothing exceeds eight clocks; multiply takes four, divide eight.
// - the opcode table spreads the instructions over the set clock counts.
// - add, add-with-carry and subtract use 1/1, 2/2, 1/2, 2/2 bytes/clocks.
// - add-with-carry adds the carry flag; the register form is 1 byte, 1 clock.
// - increment/decrement: A or Rn 1/1, direct 2/2, indirect 1/2, pointer 1.
// - logic of an immediate into a direct byte is 3 bytes, 3 clocks.
// - logic into A: Rn 1 clock, others 2; A into direct 2 bytes, 2 clocks.
module mct_core
  import mct_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // program memory
  input wire logic [7:0] i_code_byte,
  output logic [15:0] o_code_addr,
  // core state
  output logic o_instr_done,
  output logic [7:0] o_acc,
  output logic [7:0] o_flags,
  output logic [15:0] o_data_pointer
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [3:0] cnt_reg;
  logic [7:0] opc_reg;
  logic [7:0] op1_reg;
  logic [7:0] op2_reg;
  mct_timing_t tim_reg;
  logic ext_reg;
  logic done_reg;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic [7:0] b_reg;
  logic [7:0] b_next;
  logic [7:0] psw_reg;
  logic [7:0] psw_next;
  logic [15:0] data_pointer_register_reg;
  logic [15:0] data_pointer_register_next;
  logic [7:0] ram [0:255];
  logic ram_we;
  logic wr_go;
  logic [7:0] wr_val;
  mct_alu_op_t alu_op;
  mct_alu_res_t alu_res;
  mct_md_res_t md_res;

  // ---------------------------------------------------------------
  // current instruction and its bytes
  // ---------------------------------------------------------------
  wire logic first = (cnt_reg == 4'h0);
  wire logic [7:0] cur_op = first ? i_code_byte : opc_reg;
  wire mct_timing_t tm = first ? mct_timing(i_code_byte) : tim_reg;
  wire logic [7:0] op1 = (cnt_reg == 4'h1) ? i_code_byte : op1_reg;
  wire logic [7:0] op2 = (cnt_reg == 4'h2) ? i_code_byte : op2_reg;
  wire logic [3:0] hi = cur_op[7:4];
  wire logic [3:0] lo = cur_op[3:0];

  // ---------------------------------------------------------------
  // sequencing: one byte per clock, then wait clocks
  // ---------------------------------------------------------------
  // fetch while bytes remain
  wire logic fetch = (cnt_reg < {2'h0, tm.len}) && !ext_reg;
  wire logic base_end = (cnt_reg == (tm.cyc - 4'h1));
  wire logic br_taken = (cur_op == OP_JC) ? psw_reg[FLG_CY] :
                        (cur_op == OP_JNC) ? !psw_reg[FLG_CY] :
                        (cur_op == OP_JZ) ? (acc_reg == 8'h00) :
                        (cur_op == OP_JNZ) ? (acc_reg != 8'h00) :
                        (cur_op == OP_SJMP);
  // a taken jump earns one more clock
  wire logic take_ext = base_end && tm.branch && br_taken && !ext_reg;
  wire logic exec = base_end && !take_ext;
  wire logic done = exec || ext_reg;
  wire logic [7:0] rel = (tim_reg.len == 2'h3) ? op2_reg : op1_reg;

  // next program address
  assign pc_next = ext_reg ? pc_reg + {{8{rel[7]}}, rel} :
                   fetch ? pc_reg + 16'h0001 : pc_reg;

  // ---------------------------------------------------------------
  // operand addressing
  // ---------------------------------------------------------------
  wire logic is_rn = cur_op[3];
  wire logic is_ri = (lo[3:1] == 3'h3);
  wire logic is_imm = (lo == 4'h4);
  wire logic [7:0] rn_addr = {3'h0, psw_reg[FLG_RS_HI:FLG_RS_LO], cur_op[2:0]};
  wire logic [7:0] ri_loc = {3'h0, psw_reg[FLG_RS_HI:FLG_RS_LO], 2'h0, cur_op[0]};
  wire logic [7:0] ri_ptr = ram[ri_loc];
  wire logic mem_dir = !is_rn && !is_ri;
  wire logic [7:0] mem_addr = is_rn ? rn_addr : is_ri ? ri_ptr : op1;
  wire logic [7:0] dir_rd = (op1 == SFR_ACC) ? acc_reg :
                            (op1 == SFR_B) ? b_reg :
                            (op1 == SFR_PSW) ? psw_reg :
                            (op1 == SFR_DPL) ? data_pointer_register_reg[7:0] :
                            (op1 == SFR_DPH) ? data_pointer_register_reg[15:8] : ram[op1];
  wire logic [7:0] mem_rd = mem_dir ? dir_rd : ram[mem_addr];

  // ---------------------------------------------------------------
  // instruction groups
  // ---------------------------------------------------------------
  wire logic grp_arith = (hi == HI_ADD) || (hi == HI_ADDC) || (hi == HI_SUBB);
  wire logic grp_logic = (hi == HI_OR) || (hi == HI_AND) || (hi == HI_XOR);
  wire logic grp_incdec = (hi == HI_INC) || (hi == HI_DEC);
  wire logic src_form = (lo >= 4'h4);
  wire logic logic_dir = grp_logic && ((lo == 4'h2) || (lo == 4'h3));

  // alu operation by high nibble
  assign alu_op = (hi == HI_INC) ? ALU_INC :
                  (hi == HI_DEC) ? ALU_DEC :
                  (hi == HI_ADD) ? ALU_ADD :
                  (hi == HI_ADDC) ? ALU_ADDC :
                  (hi == HI_OR) ? ALU_OR :
                  (hi == HI_AND) ? ALU_AND :
                  (hi == HI_XOR) ? ALU_XOR :
                  (hi == HI_SUBB) ? ALU_SUBB : ALU_DA;

  // alu operands: memory target for inc/dec memory forms and logic into direct, else accumulator
  wire logic mem_tgt = (grp_incdec && !is_imm) || logic_dir;
  wire logic [7:0] alu_a = mem_tgt ? mem_rd : acc_reg;
  wire logic [7:0] alu_b = logic_dir ? ((lo == 4'h2) ? acc_reg : op2) :
                           is_imm ? op1 : mem_rd;

  mct_alu u_alu (
    .i_op(alu_op),
    .i_a(alu_a),
    .i_b(alu_b),
    .i_cy(psw_reg[FLG_CY]),
    .i_ac(psw_reg[FLG_AC]),
    .o_res(alu_res)
  );

  // multiply and divide loaded in the opcode clock
  wire logic md_load = first && ((i_code_byte == OP_MUL) || (i_code_byte == OP_DIV));

  mct_muldiv u_muldiv (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(md_load),
    .i_div(cur_op == OP_DIV),
    .i_a(acc_reg),
    .i_b(b_reg),
    .o_res(md_res)
  );

  // ---------------------------------------------------------------
  // execute in the last clock of an instruction
  // ---------------------------------------------------------------
  always_comb begin
    acc_next = acc_reg;
    b_next = b_reg;
    psw_next = psw_reg;
    data_pointer_register_next = data_pointer_register_reg;
    wr_go = 1'h0;
    wr_val = alu_res.res;
    ram_we = 1'h0;
    if (exec) begin
      case (cur_op)
        OP_MUL, OP_DIV: begin
          acc_next = md_res.lo;
          b_next = md_res.hi;
          psw_next[FLG_CY] = 1'h0;
          psw_next[FLG_OV] = md_res.ov;
        end
        OP_DA: begin
          acc_next = alu_res.res;
          psw_next[FLG_CY] = alu_res.cy;
        end
        OP_CLR_A: acc_next = 8'h00;
        OP_CPL_A: acc_next = ~acc_reg;
        OP_SWAP: acc_next = {acc_reg[3:0], acc_reg[7:4]};
        OP_RR: acc_next = {acc_reg[0], acc_reg[7:1]};
        OP_RL: acc_next = {acc_reg[6:0], acc_reg[7]};
        OP_RRC: begin
          acc_next = {psw_reg[FLG_CY], acc_reg[7:1]};
          psw_next[FLG_CY] = acc_reg[0];
        end
        OP_RLC: begin
          acc_next = {acc_reg[6:0], psw_reg[FLG_CY]};
          psw_next[FLG_CY] = acc_reg[7];
        end
        OP_CLR_C: psw_next[FLG_CY] = 1'h0;
        OP_SETB_C: psw_next[FLG_CY] = 1'h1;
        OP_CPL_C: psw_next[FLG_CY] = !psw_reg[FLG_CY];
        OP_INC_DP: data_pointer_register_next = data_pointer_register_reg + 16'h0001;
        OP_LD_DP: data_pointer_register_next = {op1, op2};
        OP_MOV_AI: acc_next = op1;
        default: begin
          if (grp_arith && src_form) begin
            acc_next = alu_res.res;
            psw_next[FLG_CY] = alu_res.cy;
            psw_next[FLG_AC] = alu_res.ac;
            psw_next[FLG_OV] = alu_res.ov;
          end else if (grp_logic && src_form) begin
            acc_next = alu_res.res;
          end else if (logic_dir) begin
            wr_go = 1'h1;
          end else if (grp_incdec && src_form) begin
            if (is_imm) begin
              acc_next = alu_res.res;
            end else begin
              wr_go = 1'h1;
            end
          end else if ((hi == HI_MOVA) && (lo >= 4'h5)) begin
            acc_next = mem_rd;
          end else if ((hi == HI_MOVM) && (lo >= 4'h5)) begin
            wr_go = 1'h1;
            wr_val = acc_reg;
          end else if ((hi == HI_MOVI) && (lo >= 4'h5)) begin
            wr_go = 1'h1;
            wr_val = (lo == 4'h5) ? op2 : op1; // direct form carries its constant last
          end
        end
      endcase
    end
    // writes to a direct address may land on a special register
    if (wr_go) begin
      if (mem_dir && (mem_addr == SFR_ACC)) begin
        acc_next = wr_val;
      end else if (mem_dir && (mem_addr == SFR_B)) begin
        b_next = wr_val;
      end else if (mem_dir && (mem_addr == SFR_PSW)) begin
        psw_next = wr_val;
      end else if (mem_dir && (mem_addr == SFR_DPL)) begin
        data_pointer_register_next[7:0] = wr_val;
      end else if (mem_dir && (mem_addr == SFR_DPH)) begin
        data_pointer_register_next[15:8] = wr_val;
      end else begin
        ram_we = 1'h1;
      end
    end
    // parity always tracks the accumulator
    psw_next[FLG_P] = ^acc_next;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // clock counter within the instruction
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= 4'h0;
      ext_reg <= 1'h0;
      done_reg <= 1'h0;
      pc_reg <= PC_RESET;
    end else begin
      cnt_reg <= done ? 4'h0 : cnt_reg + 4'h1;
      ext_reg <= take_ext;
      done_reg <= done;
      pc_reg <= pc_next;
    end
  end

  // opcode and operand latches
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      opc_reg <= 8'h00;
      tim_reg <= '0;
      op1_reg <= 8'h00;
      op2_reg <= 8'h00;
    end else begin
      opc_reg <= cur_op;
      tim_reg <= tm;
      op1_reg <= op1;
      op2_reg <= op2;
    end
  end

  // architectural state
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      acc_reg <= 8'h00;
      b_reg <= 8'h00;
      psw_reg <= FLAGS_RESET;
      data_pointer_register_reg <= 16'h0000;
    end else begin
      acc_reg <= acc_next;
      b_reg <= b_next;
      psw_reg <= psw_next;
      data_pointer_register_reg <= data_pointer_register_next;
    end
  end

  // data memory write port
  always_ff @(posedge i_sys_clk) begin
    if (ram_we) begin
      ram[mem_addr] <= wr_val;
    end
  end

  // outputs straight from flops
  assign o_code_addr = pc_reg;
  assign o_instr_done = done_reg;
  assign o_acc = acc_reg;
  assign o_flags = psw_reg;
  assign o_data_pointer = data_pointer_register_reg;

endmodule : mct_core

// [verif/mct_rom_model.sv]
// Purpose: program memory model answering the core in-cycle
// Assumes: fixed program of 30 bytes from address 0
// Notes: unused addresses read as all ones
module mct_rom_model (
  // fetch
  input wire logic [15:0] i_addr,
  output logic [7:0] o_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:29] = '{8'h00, 8'h74, 8'h05, 8'h24, 8'hF0, 8'h40, 8'h02, 8'h24, 8'h10,
    8'h40, 8'h01, 8'hE4, 8'hF8, 8'h38, 8'hD4, 8'hA3, 8'h75, 8'hF0, 8'h03, 8'hA4, 8'h75,
    8'hF0, 8'h04, 8'h84, 8'h53, 8'hE0, 8'h06, 8'hE4, 8'h80, 8'hFE};
  // combinational read
  assign o_byte = (i_addr < 16'h001E) ? mem[i_addr[4:0]] : 8'hFF;
endmodule : mct_rom_model

// [verif/mct_core_asserts.sv]
// Purpose: clock-count and result checks at the core ports
// Assumes: an opcode is on i_code_byte while o_instr_done is high
// Notes: bound into mct_core
module mct_core_asserts
  import mct_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_code_byte,
  input wire logic [15:0] o_code_addr,
  input wire logic o_instr_done,
  input wire logic [7:0] o_acc,
  input wire logic [7:0] o_flags,
  input wire logic [15:0] o_data_pointer
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_op(op);
    o_instr_done && i_code_byte == op;
  endsequence
  property p_mul; s_op(OP_MUL) |=> !o_instr_done [*3] ##1 o_instr_done; endproperty
  property p_div; s_op(OP_DIV) |=> !o_instr_done [*7] ##1 o_instr_done; endproperty
  property p_da; s_op(OP_DA) |=> o_instr_done; endproperty
  property p_rn; o_instr_done && i_code_byte inside {8'h28, 8'h38, 8'h98} |=> o_instr_done;
  endproperty
  property p_imm; s_op(8'h24) |-> ##2 o_instr_done &&
    o_code_addr == $past(o_code_addr, 2) + 16'h0002;
  endproperty
  property p_anl; s_op(8'h53) |=> !o_instr_done [*2] ##1
    o_code_addr == $past(o_code_addr, 3) + 16'h0003;
  endproperty
  property p_dp; s_op(OP_INC_DP) |=> o_data_pointer == $past(o_data_pointer) + 16'h0001; endproperty
  property p_jnt; o_instr_done && i_code_byte == OP_JC && !o_flags[FLG_CY] |=>
    !o_instr_done ##1 o_instr_done;
  endproperty
  property p_jt; o_instr_done && i_code_byte == OP_JC && o_flags[FLG_CY] |=>
    !o_instr_done [*2] ##1 o_instr_done;
  endproperty
  property p_clr; s_op(OP_CLR_A) |=> o_instr_done && o_acc == 8'h00; endproperty
  a_mul: assert property (p_mul) else $error("multiply length");
  a_div: assert property (p_div) else $error("divide length");
  a_da: assert property (p_da) else $error("decimal adjust length");
  a_rn: assert property (p_rn) else $error("register add length");
  a_imm: assert property (p_imm) else $error("immediate add length");
  a_anl: assert property (p_anl) else $error("logic to direct length");
  a_dp: assert property (p_dp) else $error("pointer increment");
  a_jnt: assert property (p_jnt) else $error("jump not taken length");
  a_jt: assert property (p_jt) else $error("jump taken length");
  a_clr: assert property (p_clr) else $error("clear accumulator");
endmodule : mct_core_asserts
bind mct_core mct_core_asserts i_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
  .i_code_byte(i_code_byte), .o_code_addr(o_code_addr), .o_instr_done(o_instr_done),
  .o_acc(o_acc), .o_flags(o_flags), .o_data_pointer(o_data_pointer));

// [verif/tb_top.sv]
// Purpose: runs a fixed program and checks clocks spent and results
// Assumes: cycle count starts at the first edge with reset low
// Notes: one task per program stretch
module tb_top;
  import mct_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, done;
  logic [7:0] code, acc, flags;
  logic [15:0] addr, dp;
  int err_count = 0, num_checks = 0, cyc = 0;
  mct_core i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_code_byte(code), .o_code_addr(addr),
    .o_instr_done(done), .o_acc(acc), .o_flags(flags), .o_data_pointer(dp));
  mct_rom_model i_rom (.i_addr(addr), .o_byte(code));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task run_to(input logic [15:0] a, input int n);
    for (int i = 0; i < 60 && addr !== a; i++) @(posedge clk) #1;
    check(addr, a);
    check(16'(cyc), 16'(n));
  endtask : run_to
  task t_branch;
    run_to(16'h000C, 12);
    check(acc, 8'h05);
    check(flags, 8'h80);
  endtask : t_branch
  task t_alu;
    run_to(16'h0010, 16);
    check(acc, 8'h11);
    check(dp, 16'h0001);
    check(flags, 8'h00);
  endtask : t_alu
  task t_muldiv;
    run_to(16'h0014, 20);
    repeat (2) @(posedge clk) #1;
    check(acc, 8'h11);
    @(posedge clk) #1;
    check(acc, 8'h33);
    check(addr, 16'h0014);
    run_to(16'h0018, 27);
    repeat (6) @(posedge clk) #1;
    check(acc, 8'h33);
    @(posedge clk) #1;
    check(acc, 8'h0C);
    check(addr, 16'h0018);
    check(flags, 8'h00);
  endtask : t_muldiv
  task t_logic;
    run_to(16'h001B, 37);
    check(acc, 8'h04);
    run_to(16'h001C, 38);
    check(acc, 8'h00);
  endtask : t_logic
  task tally_and_finish;
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    #5000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_branch();
    t_alu();
    t_muldiv();
    t_logic();
    tally_and_finish();
  end
endmodule : tb_top
